// File: logic/wdt_pkg.sv
package wdt_pkg;

  // ---------------------------------------------------------------
  // clocking and low-speed tick
  // ---------------------------------------------------------------
  localparam int CLK_SYS_HZ    = 40_000_000;
  localparam int LS_CLK_HZ     = 20_000;
  localparam int LS_PERIOD_NS  = 1_000_000_000 / LS_CLK_HZ;
  localparam int CLK_PERIOD_NS = 25;
  localparam int LS_DIV        = LS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_W         = 11;

  // ---------------------------------------------------------------
  // register map (byte offsets, word aligned)
  // ---------------------------------------------------------------
  localparam int        ADDR_W       = 8;
  localparam logic [7:0] OFF_KEY     = 8'h00;
  localparam logic [7:0] OFF_LOCKUP  = 8'h04;
  localparam logic [7:0] OFF_OPTION  = 8'h08;
  localparam logic [7:0] OFF_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_MASK    = 8'h10;
  localparam logic [7:0] OFF_COUNT   = 8'h14;

  localparam logic [7:0] KEY_VALUE   = 8'hAC;
  localparam logic [7:0] READ_RUN    = 8'h9A;
  localparam logic [7:0] READ_STOP   = 8'h1A;
  localparam logic [7:0] OPTION_RST  = 8'hF6;
  localparam logic       LOCKUP_RST  = 1'h0;
  localparam logic [2:0] LOCKUP_SEL  = 3'h2;
  localparam logic [1:0] WIN_75      = 2'h2;
  localparam int         STAT_W      = 1;
  localparam int         STAT_INTERVAL = 0;

  // ---------------------------------------------------------------
  // bus encodings and counter width
  // ---------------------------------------------------------------
  localparam logic [2:0] HSIZE_HALF  = 3'h1;
  localparam int         CNT_W       = 17;

  typedef struct packed {
    logic       irq_en;
    logic [1:0] window;
    logic       count_run;
    logic [2:0] period_sel;
    logic       standby_run;
  } option_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [2:0]        size;
  } ahb_req_t;

  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_RUN  = 2'b01,
    WD_TRIP = 2'b10
  } wd_state_t;

  // overflow period in low-speed cycles for a select code
  function automatic logic [CNT_W-1:0] period_cycles(input logic [2:0] sel);
    logic [CNT_W-1:0] p;
    p = 17'h00000;
    case (sel)
      3'h0:    p = 17'h00040;
      3'h1:    p = 17'h00080;
      3'h2:    p = 17'h00100;
      3'h3:    p = 17'h00200;
      3'h4:    p = 17'h00800;
      3'h5:    p = 17'h02000;
      3'h6:    p = 17'h04000;
      default: p = 17'h10000;
    endcase
    return p;
  endfunction

endpackage

// File: logic/ls_tick_gen.sv
`timescale 1ns/10ps
// low-speed tick: one-cycle enable every LS_DIV system clocks
module ls_tick_gen
(
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic run_in,
  output logic      tick_out
);

  logic [wdt_pkg::DIV_W-1:0] div_reg;
  logic [wdt_pkg::DIV_W-1:0] div_next;
  logic                      tick_reg;
  logic                      tick_next;

  // --------------------------------------------------------------
  // divider
  // --------------------------------------------------------------
  // the oscillator only runs while requested, so the phase restarts with it
  always_comb
  begin
    div_next  = div_reg;
    tick_next = 1'b0;
    if (!run_in)
    begin
      div_next = '0;
    end
    else if (div_reg == wdt_pkg::DIV_W'(wdt_pkg::LS_DIV - 1))
    begin
      div_next  = '0;
      tick_next = 1'b1;
    end
    else
    begin
      div_next = div_reg + 11'h001;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule

// File: logic/windowed_watchdog_timer.sv
`timescale 1ns/10ps
// Contract
// - counter reaching overflow period without valid restart asserts internal reset
// - three-bit select picks period 2^6,2^7,2^8,2^9,2^11,2^13,2^14,2^16 slow cycles
// - key ACH written while window open clears counter, counting resumes from zero
// - key written while window closed asserts internal reset
// - first restart write after reset ignores window, clears counter before overflow
// - window select 10 gives 75 percent, 11 gives 100 percent open
// - standby-run option zero forces a 100 percent window
// - 75 percent window closed below quarter period, open after; 100 never closed
// - interval interrupt at three quarters of period when option bit set
// - counting continues after interval interrupt; overflow without key resets
// - lockup with control bit set starts oscillator, counter, forces select 010
// - any non-key value written to restart register asserts internal reset
// - bit-manipulation access to restart register asserts internal reset
// - restart register reads 9AH when counting enabled, 1AH when disabled
// - standby-run zero stops count in sleep, clears and restarts on wake
module windowed_watchdog_timer
(
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic [31:0]      hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        lockup_in,
  input  wire logic        sleep_in,
  output logic             irq_out,
  output logic             wdt_reset_out,
  output logic             osc_enable_out
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  wdt_pkg::ahb_req_t             dph_reg;
  wdt_pkg::ahb_req_t             dph_next;
  logic                          dph_valid_reg;
  logic                          dph_valid_next;
  logic [31:0]                   rdata_reg;
  logic [31:0]                   rdata_next;

  wdt_pkg::option_t              option_reg;
  wdt_pkg::option_t              option_next;
  logic                          lockup_ctl_reg;
  logic                          lockup_ctl_next;
  logic [wdt_pkg::STAT_W-1:0]    status_reg;
  logic [wdt_pkg::STAT_W-1:0]    status_next;
  logic [wdt_pkg::STAT_W-1:0]    mask_reg;
  logic [wdt_pkg::STAT_W-1:0]    mask_next;
  logic                          irq_reg;
  logic                          irq_next;

  wdt_pkg::wd_state_t            state_reg;
  wdt_pkg::wd_state_t            state_next;
  logic [wdt_pkg::CNT_W-1:0]     count_reg;
  logic [wdt_pkg::CNT_W-1:0]     count_next;
  logic                          first_done_reg;
  logic                          first_done_next;
  logic                          clr_pend_reg;
  logic                          clr_pend_next;
  logic                          lock_active_reg;
  logic                          lock_active_next;
  logic                          sleep_d_reg;
  logic                          sleep_d_next;
  logic                          osc_reg;
  logic                          osc_next;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  logic                          addr_phase;
  logic                          key_write;
  logic                          key_bad;
  logic                          win_open;
  logic                          full_window;
  logic                          sleep_hold;
  logic                          tick;
  logic [2:0]                    sel_eff;
  logic [wdt_pkg::CNT_W-1:0]     period;
  logic [wdt_pkg::CNT_W-1:0]     count_inc;
  logic                          interval_evt;
  logic                          overflow;

  ls_tick_gen u_tick
  (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .run_in     (osc_reg),
    .tick_out   (tick)
  );

  // ---------------------------------------------------------------
  // window and period
  // ---------------------------------------------------------------
  always_comb
  begin
    addr_phase  = hsel_in & htrans_in[1] & hready_in;
    sel_eff     = lock_active_reg ? wdt_pkg::LOCKUP_SEL : option_reg.period_sel;
    period      = wdt_pkg::period_cycles(sel_eff);
    // prohibited window codes fall back to the always-open window
    full_window = !option_reg.standby_run | (option_reg.window != wdt_pkg::WIN_75);
    win_open    = full_window | (count_reg >= (period >> 2));
    sleep_hold  = sleep_in & !option_reg.standby_run;
    count_inc   = count_reg + 17'h00001;
    key_write   = dph_valid_reg & dph_reg.write & (dph_reg.addr == wdt_pkg::OFF_KEY);
    // halfword access stands in for a bit-manipulation access on this bus
    key_bad     = (dph_reg.size == wdt_pkg::HSIZE_HALF)
                | (hwdata_in[7:0] != wdt_pkg::KEY_VALUE)
                | (first_done_reg & !win_open);
  end

  // ---------------------------------------------------------------
  // counter and trip sequencing
  // ---------------------------------------------------------------
  // the clear waits for the next slow tick, so a restart lags by at most one slow cycle
  always_comb
  begin
    state_next       = state_reg;
    count_next       = count_reg;
    first_done_next  = first_done_reg;
    clr_pend_next    = clr_pend_reg;
    lock_active_next = lock_active_reg | (lockup_ctl_reg & lockup_in);
    sleep_d_next     = sleep_in;
    osc_next         = osc_reg;
    interval_evt     = 1'b0;
    overflow         = 1'b0;
    case (state_reg)
      wdt_pkg::WD_IDLE:
      begin
        count_next    = '0;
        clr_pend_next = 1'b0;
        if (option_reg.count_run | lock_active_next)
        begin
          state_next = wdt_pkg::WD_RUN;
          osc_next   = 1'b1;
        end
      end
      wdt_pkg::WD_RUN:
      begin
        if (key_write)
        begin
          first_done_next = 1'b1;
          if (key_bad)
          begin
            state_next = wdt_pkg::WD_TRIP;
          end
          else
          begin
            clr_pend_next = 1'b1;
          end
        end
        if (sleep_d_reg & !sleep_in & !option_reg.standby_run)
        begin
          count_next    = '0;
          clr_pend_next = 1'b0;
        end
        else if (tick & !sleep_hold)
        begin
          if (clr_pend_reg)
          begin
            count_next    = '0;
            clr_pend_next = key_write & !key_bad;
          end
          else
          begin
            count_next = count_inc;
            if (count_inc == period)
            begin
              overflow = 1'b1;
            end
            if (option_reg.irq_en & (count_inc == (period - (period >> 2))))
            begin
              interval_evt = 1'b1;
            end
          end
        end
        if (overflow)
        begin
          state_next = wdt_pkg::WD_TRIP;
        end
      end
      wdt_pkg::WD_TRIP:
      begin
        state_next = wdt_pkg::WD_TRIP;
      end
      default:
      begin
        state_next = wdt_pkg::WD_TRIP;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_reg       <= wdt_pkg::WD_IDLE;
      count_reg       <= '0;
      first_done_reg  <= 1'b0;
      clr_pend_reg    <= 1'b0;
      lock_active_reg <= 1'b0;
      sleep_d_reg     <= 1'b0;
      osc_reg         <= 1'b0;
    end
    else
    begin
      state_reg       <= state_next;
      count_reg       <= count_next;
      first_done_reg  <= first_done_next;
      clr_pend_reg    <= clr_pend_next;
      lock_active_reg <= lock_active_next;
      sleep_d_reg     <= sleep_d_next;
      osc_reg         <= osc_next;
    end
  end

  // ---------------------------------------------------------------
  // bus slave and registers
  // ---------------------------------------------------------------
  // zero wait states: read data is prepared in the address phase
  always_comb
  begin
    dph_valid_next  = addr_phase;
    dph_next        = dph_reg;
    rdata_next      = rdata_reg;
    option_next     = option_reg;
    lockup_ctl_next = lockup_ctl_reg;
    mask_next       = mask_reg;
    status_next     = status_reg;
    if (addr_phase)
    begin
      dph_next.write = hwrite_in;
      dph_next.addr  = haddr_in[wdt_pkg::ADDR_W-1:0];
      dph_next.size  = hsize_in;
      rdata_next     = 32'h00000000;
      if (!hwrite_in)
      begin
        case (haddr_in[wdt_pkg::ADDR_W-1:0])
          wdt_pkg::OFF_KEY:
            rdata_next[7:0] = option_reg.count_run ? wdt_pkg::READ_RUN : wdt_pkg::READ_STOP;
          wdt_pkg::OFF_LOCKUP:
            rdata_next[0] = lockup_ctl_reg;
          wdt_pkg::OFF_OPTION:
            rdata_next[7:0] = option_reg;
          wdt_pkg::OFF_STATUS:
          begin
            rdata_next[wdt_pkg::STAT_W-1:0] = status_reg;
            status_next = '0;                                                   // read clears
          end
          wdt_pkg::OFF_MASK:
            rdata_next[wdt_pkg::STAT_W-1:0] = mask_reg;
          wdt_pkg::OFF_COUNT:
            rdata_next[wdt_pkg::CNT_W-1:0] = count_reg;
          default:
            rdata_next = 32'h00000000;
        endcase
      end
    end
    if (dph_valid_reg & dph_reg.write)
    begin
      case (dph_reg.addr)
        wdt_pkg::OFF_LOCKUP: lockup_ctl_next = hwdata_in[0];
        wdt_pkg::OFF_OPTION: option_next     = hwdata_in[7:0];
        wdt_pkg::OFF_MASK:   mask_next       = hwdata_in[wdt_pkg::STAT_W-1:0];
        default:             mask_next       = mask_reg;
      endcase
    end
    // an event in the clearing read cycle still lands
    if (interval_evt)
    begin
      status_next[wdt_pkg::STAT_INTERVAL] = 1'b1;
    end
    irq_next = |(status_next & mask_next);
  end

  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      dph_reg        <= '0;
      dph_valid_reg  <= 1'b0;
      rdata_reg      <= 32'h00000000;
      option_reg     <= wdt_pkg::OPTION_RST;
      lockup_ctl_reg <= wdt_pkg::LOCKUP_RST;
      status_reg     <= '0;
      mask_reg       <= '0;
      irq_reg        <= 1'b0;
    end
    else
    begin
      dph_reg        <= dph_next;
      dph_valid_reg  <= dph_valid_next;
      rdata_reg      <= rdata_next;
      option_reg     <= option_next;
      lockup_ctl_reg <= lockup_ctl_next;
      status_reg     <= status_next;
      mask_reg       <= mask_next;
      irq_reg        <= irq_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the reset request holds until the system reset comes back in
  assign hrdata_out     = rdata_reg;
  assign hreadyout_out  = 1'b1;
  assign hresp_out      = 1'b0;
  assign irq_out        = irq_reg;
  assign wdt_reset_out  = (state_reg == wdt_pkg::WD_TRIP);
  assign osc_enable_out = osc_reg;

endmodule

// File: tb/wdt_monitor.sv
`timescale 1ns/10ps
// ---------------------------------------------
// port-level watchdog monitor
// ---------------------------------------------
module wdt_monitor
(
  input wire logic        clk_sys_in,
  input wire logic        reset_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [2:0]  hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  input wire logic        lockup_in,
  input wire logic        sleep_in,
  input wire logic        irq_out,
  input wire logic        wdt_reset_out,
  input wire logic        osc_enable_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  logic             dp_v;
  logic             dp_w;
  logic [7:0]       dp_a;
  logic [2:0]       dp_s;
  logic             lock_bit;
  logic             mask_bit;
  wdt_pkg::option_t opt_seen;

  // remember the address phase so the data phase can be judged
  always_ff @(posedge clk_sys_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      dp_v     <= 1'b0;
      dp_w     <= 1'b0;
      dp_a     <= 8'h00;
      dp_s     <= 3'h0;
      lock_bit <= 1'b0;
      mask_bit <= 1'b0;
      opt_seen <= wdt_pkg::OPTION_RST;
    end
    else
    begin
      dp_v     <= hsel_in & htrans_in[1] & hready_in;
      dp_w     <= hwrite_in;
      dp_a     <= haddr_in[7:0];
      dp_s     <= hsize_in;
      lock_bit <= (dp_v && dp_w && dp_a == wdt_pkg::OFF_LOCKUP) ? hwdata_in[0] : lock_bit;
      mask_bit <= (dp_v && dp_w && dp_a == wdt_pkg::OFF_MASK) ? hwdata_in[0] : mask_bit;
      // the key read-back follows the run bit of the option byte last written
      opt_seen <= (dp_v && dp_w && dp_a == wdt_pkg::OFF_OPTION) ? wdt_pkg::option_t'(hwdata_in[7:0]) : opt_seen;
    end
  end

  sequence s_wr_key;
    dp_v && dp_w && dp_a == wdt_pkg::OFF_KEY;
  endsequence

  sequence s_rd(logic [7:0] a);
    dp_v && !dp_w && dp_a == a;
  endsequence

  a_trip_sticky: assert property (wdt_reset_out |=> wdt_reset_out)
    else $error("reset request dropped");
  a_bad_key_trip: assert property (s_wr_key ##0 (hwdata_in[7:0] != wdt_pkg::KEY_VALUE)
    |-> ##[1:2] wdt_reset_out)
    else $error("wrong key did not trip");
  a_half_key_trip: assert property (s_wr_key ##0 (dp_s == wdt_pkg::HSIZE_HALF) |-> ##[1:2] wdt_reset_out)
    else $error("halfword key access did not trip");
  a_key_readback: assert property (s_rd(wdt_pkg::OFF_KEY)
    |-> hrdata_out == {24'h0, (opt_seen.count_run ? wdt_pkg::READ_RUN : wdt_pkg::READ_STOP)})
    else $error("key register read value wrong");
  a_count_bound: assert property (s_rd(wdt_pkg::OFF_COUNT) |-> hrdata_out <= 32'h00010000)
    else $error("counter beyond longest period");
  a_lockup_osc: assert property (lock_bit && lockup_in |-> ##[0:3] osc_enable_out)
    else $error("lockup did not start oscillator");
  a_irq_masked: assert property (irq_out |-> mask_bit || $past(mask_bit))
    else $error("interrupt while masked");
  a_irq_clear: assert property (s_rd(wdt_pkg::OFF_STATUS) |-> ##[2:3] !irq_out)
    else $error("status read did not clear interrupt");
  a_unmapped_zero: assert property (s_rd(dp_a) ##0 (dp_a >= 8'h18) |-> hrdata_out == 32'h0)
    else $error("unmapped read not zero");
endmodule

bind windowed_watchdog_timer wdt_monitor i_wdt_monitor (.clk_sys_in, .reset_in, .hsel_in, .haddr_in, .htrans_in,
  .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .lockup_in, .sleep_in,
  .irq_out, .wdt_reset_out, .osc_enable_out);

// File: tb/tb.sv
`timescale 1ns/10ps
module tb;
  logic        clk_sys_in = 1'b0;
  logic        reset_in   = 1'b1;
  logic        hsel_in    = 1'b0;
  logic [31:0] haddr_in   = 32'h0;
  logic [1:0]  htrans_in  = 2'h0;
  logic        hwrite_in  = 1'b0;
  logic [2:0]  hsize_in   = 3'h2;
  logic [31:0] hwdata_in  = 32'h0;
  logic        lockup_in  = 1'b0;
  logic        sleep_in   = 1'b0;
  logic        hready_in;
  logic [31:0] hrdata_out;
  logic        hreadyout_out, hresp_out, irq_out, wdt_reset_out, osc_enable_out;
  int          fails = 0;
  int          n_tests = 0;
  logic [31:0] v;
  logic [31:0] c;
  logic [7:0]  k;
  // option bytes: 75% standby on, 75% standby off, 100%, prohibited code
  logic [7:0]  opt [4] = '{8'hD1, 8'hD0, 8'hF1, 8'hB1};
  logic        exp_trip [4] = '{1'b1, 1'b0, 1'b0, 1'b0};

  assign hready_in = hreadyout_out;
  always #12.5 clk_sys_in = ~clk_sys_in;

  windowed_watchdog_timer i_windowed_watchdog_timer (.clk_sys_in, .reset_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hsize_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out, .lockup_in,
    .sleep_in, .irq_out, .wdt_reset_out, .osc_enable_out);

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // period in slow ticks, written out here so it is independent of the package
  function automatic int period_of(input int sel);
    int sh [8] = '{6, 7, 8, 9, 11, 13, 14, 16};
    return 1 << sh[sel];
  endfunction

  task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_bit(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask

  // one single transfer; read data is taken at the data-phase edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [2:0] sz, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h0, a};
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    hsize_in  <= sz;
    do @(posedge clk_sys_in); while (hready_in !== 1'b1);
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge clk_sys_in); while (hready_in !== 1'b1);
    rd = hrdata_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, 3'h2, d, x);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus(1'b0, a, 3'h2, 32'h0, d);
  endtask

  task automatic ticks(input int n);
    repeat (n * wdt_pkg::LS_DIV) @(posedge clk_sys_in);
  endtask

  task automatic do_reset;
    reset_in <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ---------------------------------------------
  // hang guard, well beyond the ~118k cycles the tests need
  // ---------------------------------------------
  initial
  begin
    repeat (200000) @(posedge clk_sys_in);
    fails++;
    $display("mismatch watchdog expected finish seen timeout");
    wrap_up();
  end

  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial
  begin
    v = $urandom(32'hC455C2C2);
    do_reset();
    rd(wdt_pkg::OFF_KEY, v);
    chk_word("key read run", {24'h0, wdt_pkg::READ_RUN}, v);
    chk_bit("bus response", 1'b0, hresp_out);
    rd(wdt_pkg::OFF_OPTION, v);
    chk_word("option reset", {24'h0, wdt_pkg::OPTION_RST}, v);
    wr(wdt_pkg::OFF_LOCKUP, 32'h0);
    rd(wdt_pkg::OFF_LOCKUP, v);
    chk_word("lockup reset", 32'h0, v);
    k = 8'h18 + 8'(($urandom % 58) * 4);
    wr(k, $urandom);
    rd(k, v);
    chk_word("unmapped", 32'h0, v);
    wr(wdt_pkg::OFF_OPTION, 32'hE6);
    rd(wdt_pkg::OFF_KEY, v);
    chk_word("key read stop", {24'h0, wdt_pkg::READ_STOP}, v);
    $display("test registers done");
    // wrong values and a halfword access must trip even as the first write
    for (int i = 0; i < 4; i++)
    begin
      do_reset();
      k = 8'($urandom);
      if (k == wdt_pkg::KEY_VALUE)
        k = 8'h00;
      if (i == 3)
        bus(1'b1, wdt_pkg::OFF_KEY, wdt_pkg::HSIZE_HALF, {24'h0, wdt_pkg::KEY_VALUE}, v);
      else
        wr(wdt_pkg::OFF_KEY, {24'h0, k});
      repeat (3) @(posedge clk_sys_in);
      chk_bit("bad key trip", 1'b1, wdt_reset_out);
    end
    $display("test bad key done");
    // back-to-back keys at count zero: only a closed window trips
    for (int i = 0; i < 4; i++)
    begin
      do_reset();
      wr(wdt_pkg::OFF_OPTION, {24'h0, opt[i]});
      wr(wdt_pkg::OFF_KEY, {24'h0, wdt_pkg::KEY_VALUE});
      repeat (3) @(posedge clk_sys_in);
      chk_bit("first key", 1'b0, wdt_reset_out);
      wr(wdt_pkg::OFF_KEY, {24'h0, wdt_pkg::KEY_VALUE});
      repeat (3) @(posedge clk_sys_in);
      chk_bit("second key", exp_trip[i], wdt_reset_out);
    end
    $display("test window done");
    // interval event, masked then unmasked, cleared by status read
    do_reset();
    wr(wdt_pkg::OFF_MASK, 32'h0);
    wr(wdt_pkg::OFF_OPTION, 32'hD1);
    wr(wdt_pkg::OFF_KEY, {24'h0, wdt_pkg::KEY_VALUE});
    ticks(50);
    chk_bit("irq masked", 1'b0, irq_out);
    wr(wdt_pkg::OFF_MASK, 32'h1);
    repeat (3) @(posedge clk_sys_in);
    chk_bit("irq raised", 1'b1, irq_out);
    rd(wdt_pkg::OFF_STATUS, v);
    chk_word("status set", 32'h1, v);
    repeat (3) @(posedge clk_sys_in);
    chk_bit("irq cleared", 1'b0, irq_out);
    rd(wdt_pkg::OFF_STATUS, v);
    chk_word("status cleared", 32'h0, v);
    rd(wdt_pkg::OFF_COUNT, v);
    chk_bit("count past event", 1'b1, v >= 3 * period_of(0) / 4 && v < period_of(0));
    wr(wdt_pkg::OFF_KEY, {24'h0, wdt_pkg::KEY_VALUE});
    repeat (3) @(posedge clk_sys_in);
    chk_bit("open window key", 1'b0, wdt_reset_out);
    ticks(2);
    rd(wdt_pkg::OFF_COUNT, v);
    chk_bit("count restarted", 1'b1, v <= 2);
    $display("test interval done");
    // standby off: frozen in sleep, restarted from zero on wake
    do_reset();
    ticks(3);
    sleep_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rd(wdt_pkg::OFF_COUNT, c);
    ticks(2);
    rd(wdt_pkg::OFF_COUNT, v);
    chk_word("count frozen", c, v);
    sleep_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rd(wdt_pkg::OFF_COUNT, v);
    chk_bit("count woken", 1'b1, v <= 1);
    $display("test sleep done");
    // lockup with the option run bit cleared: oscillator on, counter still running from reset
    do_reset();
    wr(wdt_pkg::OFF_OPTION, 32'hE6);
    wr(wdt_pkg::OFF_LOCKUP, 32'h1);
    lockup_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk_bit("osc on", 1'b1, osc_enable_out);
    rd(wdt_pkg::OFF_COUNT, c);
    ticks(2);
    rd(wdt_pkg::OFF_COUNT, v);
    chk_bit("count runs", 1'b1, v > c);
    lockup_in <= 1'b0;
    $display("test lockup done");
    wrap_up();
  end
endmodule
